// ===== pkg/dcache_pkg.sv
// Package of constants and types for the data cache controller.
// Summary of operation
// - Whole icache flush needs zero operand, clears all.
// - Whole flush also drops locked lines.
// - Single-line flush invalidates line at operand address.
// - Four-way, physical index, read-miss allocate, 8-word fill.
// - Write-back hit updates line, sets half dirty.
// - Write-through hit updates line, forwards store.
// - Store miss goes to write buffer, no allocate.
// - Dirty valid victim halves pushed before refill.
// - Control bit 2 enables only with protection on.
// - Reset disables cache and invalidates all lines.
// - Disabled: no lookup, all external, cachable forced 0.
// - Attribute pair selects write-back or write-through.
// - Enabled accesses look up; load hit needs cachable.
// - Cachable load miss fills pseudo-random segment.
// - Noncachable load miss goes external, cache unchanged.
// - Store hit updates only when cachable; misses buffered.
// - Multi-word transfers split at 4KB boundaries.
// - Whole and single-line invalidate without write-back.
// - Clean pushes dirty line; clean-flush also invalidates.
// - Index field tops at N from cache size.
// - Lockdown by segment from zero, at most three.
// - Data lockdown needs only the lockdown register.
// - Reset clears valids; only valid lines hit.
// - Replacement counter skips locked segments.
// - Load bit 31 steers fills to segment field.
package dcache_pkg;
  localparam int          SETS_LOG2   = 5;                 // 4KB cache: 32 sets per way.
  localparam int          IDX_LSB     = 5;
  localparam int          IDX_MSB     = IDX_LSB + SETS_LOG2 - 1;
  localparam int          TAG_LSB     = IDX_MSB + 1;
  localparam int          TAG_W       = 32 - TAG_LSB;
  localparam int          N_TOP       = IDX_MSB;          // Top of index field, 9 for 4KB.
  localparam int          WORDS       = 8;
  localparam int          SEG_MSB     = 31;
  localparam int          SEG_LSB     = 30;
  localparam int          PAGE_LSB    = 12;               // 4KB split boundary.
  localparam int          CTL_DC_BIT  = 2;
  localparam int          CTL_PU_BIT  = 0;
  localparam int          LOAD_BIT    = 31;
  // Cache operation codes carried on the operation port.
  localparam logic [3:0]  OP_IC_ALL   = 4'h1;
  localparam logic [3:0]  OP_IC_LINE  = 4'h2;
  localparam logic [3:0]  OP_DC_ALL   = 4'h3;
  localparam logic [3:0]  OP_DC_LINE  = 4'h4;
  localparam logic [3:0]  OP_CLN_IDX  = 4'h5;
  localparam logic [3:0]  OP_CLN_ADR  = 4'h6;
  localparam logic [3:0]  OP_CF_IDX   = 4'h7;
  localparam logic [3:0]  OP_CF_ADR   = 4'h8;
  localparam logic [15:0] LFSR_SEED   = 16'hACE1;
  localparam logic [15:0] LFSR_TAPS   = 16'hB400;
  // AXI4-Lite map.
  localparam logic [7:0]  A_CTRL      = 8'h00;            // Bit 2 cache, bit 0 protection.
  localparam logic [7:0]  A_LOCK      = 8'h04;            // Bit 31 load, bits 1:0 segment.
  localparam logic [7:0]  A_CACHEOP   = 8'h08;            // Write operand, code in ...
  localparam logic [7:0]  A_OPCODE    = 8'h0C;            // ... this register.
  localparam logic [7:0]  A_STATUS    = 8'h10;            // Read-only state.
  localparam logic [7:0]  A_ICLINE    = 8'h14;            // Read-only icache valid bits.
  localparam logic [1:0]  RESP_OK     = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;
  typedef enum logic [2:0] {ST_IDLE, ST_EVICT, ST_FILL, ST_OPPUSH, ST_EXT} state_t;
endpackage : dcache_pkg

// ===== rtl/dcache_ctrl.sv
// Data cache controller with AXI4-Lite control registers.
`timescale 1ns/10ps
`default_nettype none
module dcache_ctrl
  import dcache_pkg::*;
(
  input  wire logic        CLK_SYS_I,
  input  wire logic        ARST_N_I,
  // AXI4-Lite slave.
  input  wire logic [7:0]  AWADDR_I,
  input  wire logic        AWVALID_I,
  output logic             AWREADY_O,
  input  wire logic [31:0] WDATA_I,
  input  wire logic [3:0]  WSTRB_I,
  input  wire logic        WVALID_I,
  output logic             WREADY_O,
  output logic [1:0]       BRESP_O,
  output logic             BVALID_O,
  input  wire logic        BREADY_I,
  input  wire logic [7:0]  ARADDR_I,
  input  wire logic        ARVALID_I,
  output logic             ARREADY_O,
  output logic [31:0]      RDATA_O,
  output logic [1:0]       RRESP_O,
  output logic             RVALID_O,
  input  wire logic        RREADY_I,
  // Core port: one access held until CORE_DONE_O.
  input  wire logic        CORE_REQ_I,
  input  wire logic        CORE_WR_I,
  input  wire logic [31:0] CORE_ADDR_I,
  input  wire logic [31:0] CORE_WDATA_I,
  input  wire logic        CACHABLE_ATTR_I,
  input  wire logic        BUFFERABLE_ATTR_I,
  input  wire logic        CORE_LAST_I,
  output logic             CORE_DONE_O,
  output logic [31:0]      CORE_RDATA_O,
  output logic             CORE_SPLIT_O,
  // Write buffer push, one word per accepted cycle.
  output logic             WB_VALID_O,
  output logic [31:0]      WB_ADDR_O,
  output logic [31:0]      WB_DATA_O,
  output logic             WB_BUFFERED_O,
  input  wire logic        WB_READY_I,
  // External read: single word or eight-word linefill.
  output logic             EXT_REQ_O,
  output logic [31:0]      EXT_ADDR_O,
  output logic             EXT_FILL_O,
  input  wire logic        EXT_VALID_I,
  input  wire logic [31:0] EXT_DATA_I,
  output logic [7:0]       ICACHE_INVAL_O
);
  localparam int LINES = 1 << SETS_LOG2;
  // Arrays for tags, flags and data of four ways.
  logic [TAG_W-1:0] tag_r   [4][LINES];
  logic [31:0]      data_r  [4][LINES][WORDS];
  logic [LINES-1:0] valid_r [4];
  logic [LINES-1:0] dirty_r [4][2];                  // One flag per half line.
  logic [LINES-1:0] ivalid_r;                        // Icache valid per set, all ways folded.
  logic [31:0]      ctrl_r, lock_r, opnd_r;
  logic [3:0]       opcode_r;
  logic             op_pend_r;
  logic [15:0]      lfsr_r;
  state_t           st_r;
  logic [2:0]       cnt_r;
  logic [1:0]       way_r;
  logic             half_r;
  logic [SETS_LOG2-1:0] set_r;
  logic             opinv_r;
  // Bus channel latches.
  logic             aw_hold_r, w_hold_r;
  logic [7:0]       awaddr_r;
  logic [31:0]      wdata_r;

  // Decode that appears for both core and operand addresses.
  function automatic logic [SETS_LOG2-1:0] set_of(input logic [31:0] a);
    return a[IDX_MSB:IDX_LSB];
  endfunction

  // Cache is live only with protection enabled too.
  wire enabled = ctrl_r[CTL_DC_BIT] & ctrl_r[CTL_PU_BIT];
  wire cach    = CACHABLE_ATTR_I & enabled;
  wire [SETS_LOG2-1:0] cset = set_of(CORE_ADDR_I);
  wire [TAG_W-1:0]     ctag = CORE_ADDR_I[31:TAG_LSB];
  logic [3:0] hitv;
  genvar g;
  generate
    for (g = 0; g < 4; g++) begin : g_cmp
      assign hitv[g] = enabled & valid_r[g][cset] & (tag_r[g][cset] == ctag);
    end
  endgenerate
  wire       hit  = |hitv;
  wire [1:0] hway = hitv[3] ? 2'd3 : hitv[2] ? 2'd2 : hitv[1] ? 2'd1 : 2'd0;
  // Unlocked range starts at the lock segment; load mode forces the segment.
  wire [1:0] lseg = lock_r[1:0];
  // Span of unlocked ways is three bits wide, so an unlocked cache gives four and never a zero divisor.
  wire [2:0] span = 3'd4 - {1'b0, lseg};
  wire [1:0] rnd  = lseg + 2'({1'b0, lfsr_r[1:0]} % span);
  wire [1:0] victim = lock_r[LOAD_BIT] ? lseg : rnd;
  // Maintenance operand decode.
  wire byidx = (opcode_r == OP_CLN_IDX) | (opcode_r == OP_CF_IDX);
  wire [SETS_LOG2-1:0] oset = set_of(opnd_r);
  logic [3:0] ohitv;
  generate
    for (g = 0; g < 4; g++) begin : g_ocmp
      assign ohitv[g] = valid_r[g][oset] & (tag_r[g][oset] == opnd_r[31:TAG_LSB]);
    end
  endgenerate
  wire [1:0] oway = byidx ? opnd_r[SEG_MSB:SEG_LSB] :
                    ohitv[3] ? 2'd3 : ohitv[2] ? 2'd2 : ohitv[1] ? 2'd1 : 2'd0;
  wire ofound = byidx ? valid_r[oway][oset] : |ohitv;
  // Split flag: last word of a page while more words of the transfer follow.
  wire crosses = CORE_ADDR_I[PAGE_LSB-1:2] == '1 & ~CORE_LAST_I;
  // A word still waiting at the buffer port blocks new accesses, so it is never overwritten.
  wire idle_go = (st_r == ST_IDLE) & ~op_pend_r & ~WB_VALID_O & CORE_REQ_I & ~CORE_DONE_O;
  wire wb_fire = WB_VALID_O & WB_READY_I;
  wire aw_take = AWVALID_I & AWREADY_O;
  wire w_take  = WVALID_I & WREADY_O;
  wire wr_go   = aw_hold_r & w_hold_r & ~BVALID_O;
  wire [31:0] wmask = {{8{WSTRB_I[3]}}, {8{WSTRB_I[2]}}, {8{WSTRB_I[1]}}, {8{WSTRB_I[0]}}};
  wire wr_ok = (awaddr_r == A_CTRL) | (awaddr_r == A_LOCK) | (awaddr_r == A_CACHEOP) | (awaddr_r == A_OPCODE);
  wire [31:0] rd_mux = (ARADDR_I == A_CTRL)   ? ctrl_r :
                       (ARADDR_I == A_LOCK)   ? lock_r :
                       (ARADDR_I == A_CACHEOP)? opnd_r :
                       (ARADDR_I == A_OPCODE) ? {28'h0000000, opcode_r} :
                       (ARADDR_I == A_STATUS) ? {24'h000000, 2'h0, op_pend_r, enabled, 1'b0, 3'(st_r)} :
                       (ARADDR_I == A_ICLINE) ? 32'(ivalid_r) : 32'h00000000;
  wire rd_ok = (ARADDR_I <= A_ICLINE) & (ARADDR_I[1:0] == 2'h0);

  // Bus slave: address and data held separately, response once both are in.
  // Each ready drops after a take, so at most one write is held; it commits once the earlier response is taken.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      aw_hold_r <= 1'b0;
      w_hold_r  <= 1'b0;
      awaddr_r  <= 8'h00;
      wdata_r   <= 32'h00000000;
      BVALID_O  <= 1'b0;
      BRESP_O   <= RESP_OK;
      ARREADY_O <= 1'b0;
      RVALID_O  <= 1'b0;
      RDATA_O   <= 32'h00000000;
      RRESP_O   <= RESP_OK;
      AWREADY_O <= 1'b0;
      WREADY_O  <= 1'b0;
    end else begin
      AWREADY_O <= ~aw_hold_r & ~aw_take;
      WREADY_O  <= ~w_hold_r & ~w_take;
      // Address side latched on its own handshake.
      if (aw_take) begin
        aw_hold_r <= 1'b1;
        awaddr_r  <= AWADDR_I;
      end
      // Data side masked by the byte strobes as it is taken.
      if (w_take) begin
        w_hold_r <= 1'b1;
        wdata_r  <= WDATA_I & wmask;
      end
      // Both halves in: commit and answer; an unmapped offset answers with an error.
      if (wr_go) begin
        aw_hold_r <= 1'b0;
        w_hold_r  <= 1'b0;
        BVALID_O  <= 1'b1;
        BRESP_O   <= wr_ok ? RESP_OK : RESP_SLVERR;
      end else if (BREADY_I) BVALID_O <= 1'b0;
      ARREADY_O <= ARVALID_I & ~ARREADY_O & ~RVALID_O;
      // Read data is captured at the address handshake and held until taken.
      if (ARVALID_I & ARREADY_O) begin
        RVALID_O <= 1'b1;
        RDATA_O  <= rd_mux;
        RRESP_O  <= rd_ok ? RESP_OK : RESP_SLVERR;
      end else if (RREADY_I) RVALID_O <= 1'b0;
    end
  end

  // Register writes; an opcode write queues the maintenance operation.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      ctrl_r    <= 32'h00000000;
      lock_r    <= 32'h00000000;
      opnd_r    <= 32'h00000000;
      opcode_r  <= 4'h0;
      op_pend_r <= 1'b0;
    end else begin
      if (wr_go & (awaddr_r == A_CTRL))    ctrl_r <= wdata_r;
      if (wr_go & (awaddr_r == A_LOCK))    lock_r <= wdata_r;
      if (wr_go & (awaddr_r == A_CACHEOP)) opnd_r <= wdata_r;
      // A new code is ignored while one is still running.
      if (wr_go & (awaddr_r == A_OPCODE) & ~op_pend_r) begin
        opcode_r  <= wdata_r[3:0];
        op_pend_r <= 1'b1;
      end
      // One-step operations finish in the idle cycle that runs them.
      else if (st_r == ST_IDLE & op_pend_r & ~(ofound & opcode_r >= OP_CLN_IDX)) op_pend_r <= 1'b0;
      // A clean ends with its last word slot, whether or not that word was dirty.
      else if (st_r == ST_OPPUSH & cnt_r == 3'(WORDS-1) & (~WB_VALID_O | wb_fire)) op_pend_r <= 1'b0;
    end
  end

  // Pseudo-random source for segment choice.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) lfsr_r <= LFSR_SEED;
    else lfsr_r <= lfsr_r[0] ? ((lfsr_r >> 1) ^ LFSR_TAPS) : (lfsr_r >> 1);
  end

  // Main engine: lookups, fills, evictions, maintenance.
  always_ff @(posedge CLK_SYS_I or negedge ARST_N_I) begin
    if (!ARST_N_I) begin
      st_r    <= ST_IDLE;
      cnt_r   <= 3'h0;
      way_r   <= 2'h0;
      half_r  <= 1'b0;
      set_r   <= '0;
      opinv_r <= 1'b0;
      // Every line comes out of reset invalid and clean.
      for (int w = 0; w < 4; w++) begin
        valid_r[w]    <= '0;
        dirty_r[w][0] <= '0;
        dirty_r[w][1] <= '0;
      end
      ivalid_r       <= '0;
      CORE_DONE_O    <= 1'b0;
      CORE_RDATA_O   <= 32'h00000000;
      CORE_SPLIT_O   <= 1'b0;
      WB_VALID_O     <= 1'b0;
      WB_ADDR_O      <= 32'h00000000;
      WB_DATA_O      <= 32'h00000000;
      WB_BUFFERED_O  <= 1'b0;
      EXT_REQ_O      <= 1'b0;
      EXT_ADDR_O     <= 32'h00000000;
      EXT_FILL_O     <= 1'b0;
      ICACHE_INVAL_O <= 8'h00;
    end else begin
      CORE_DONE_O <= 1'b0;
      ICACHE_INVAL_O <= 8'h00;
      if (wb_fire) WB_VALID_O <= 1'b0;
      case (st_r)
        ST_IDLE: begin
          if (op_pend_r) begin
            case (opcode_r)
              OP_IC_ALL: if (opnd_r == 32'h00000000) begin ivalid_r <= '0; ICACHE_INVAL_O <= 8'hFF; end
              OP_IC_LINE: ICACHE_INVAL_O <= 8'(oset);
              OP_DC_ALL: for (int w = 0; w < 4; w++) valid_r[w] <= '0;
              OP_DC_LINE: if (ofound) valid_r[oway][oset] <= 1'b0;
              default: if (ofound) begin
                set_r <= oset; way_r <= oway; cnt_r <= 3'h0;
                opinv_r <= (opcode_r == OP_CF_IDX) | (opcode_r == OP_CF_ADR);
                st_r <= ST_OPPUSH;
              end
            endcase
          end else if (idle_go) begin
            CORE_SPLIT_O <= crosses;
            if (CORE_WR_I) begin
              if (hit & cach) begin
                data_r[hway][cset][CORE_ADDR_I[4:2]] <= CORE_WDATA_I;
                if (BUFFERABLE_ATTR_I) dirty_r[hway][CORE_ADDR_I[4]][cset] <= 1'b1;
              end
              if (!(hit & cach & BUFFERABLE_ATTR_I)) begin
                WB_VALID_O <= 1'b1; WB_ADDR_O <= CORE_ADDR_I; WB_DATA_O <= CORE_WDATA_I;
                WB_BUFFERED_O <= BUFFERABLE_ATTR_I; st_r <= ST_EXT;
              end else CORE_DONE_O <= 1'b1;
            end else if (hit & cach) begin
              CORE_RDATA_O <= data_r[hway][cset][CORE_ADDR_I[4:2]]; CORE_DONE_O <= 1'b1;
            end else if (cach) begin
              way_r <= victim; set_r <= cset; half_r <= 1'b0; cnt_r <= 3'h0; st_r <= ST_EVICT;
            end else begin
              EXT_REQ_O <= 1'b1; EXT_ADDR_O <= CORE_ADDR_I; EXT_FILL_O <= 1'b0; st_r <= ST_EXT;
            end
          end
        end
        ST_EVICT: begin
          if (!WB_VALID_O | wb_fire) begin
            if (valid_r[way_r][set_r] & dirty_r[way_r][half_r][set_r]) begin
              WB_VALID_O <= 1'b1; WB_BUFFERED_O <= 1'b1;
              WB_ADDR_O <= {tag_r[way_r][set_r], set_r, half_r, cnt_r[1:0], 2'b00};
              WB_DATA_O <= data_r[way_r][set_r][{half_r, cnt_r[1:0]}];
              cnt_r <= cnt_r + 3'h1;
              if (cnt_r[1:0] == 2'h3) begin
                cnt_r <= 3'h0; half_r <= ~half_r;
                dirty_r[way_r][half_r][set_r] <= 1'b0;
                if (half_r) st_r <= ST_FILL;
              end
            end else begin
              half_r <= ~half_r; cnt_r <= 3'h0;
              if (half_r) st_r <= ST_FILL;
            end
            if (half_r & cnt_r[1:0] == 2'h3 | half_r & ~(valid_r[way_r][set_r] & dirty_r[way_r][1][set_r])) begin
              valid_r[way_r][set_r] <= 1'b0;
              EXT_REQ_O <= 1'b1; EXT_FILL_O <= 1'b1; EXT_ADDR_O <= {CORE_ADDR_I[31:5], 5'h00};
            end
          end
        end
        ST_FILL: if (EXT_VALID_I) begin
          data_r[way_r][set_r][cnt_r] <= EXT_DATA_I;
          if (cnt_r == CORE_ADDR_I[4:2]) CORE_RDATA_O <= EXT_DATA_I;
          cnt_r <= cnt_r + 3'h1;
          if (cnt_r == 3'(WORDS-1)) begin
            // Line complete: tag and flags are written together with the done pulse.
            EXT_REQ_O <= 1'b0;
            tag_r[way_r][set_r] <= ctag;
            valid_r[way_r][set_r] <= 1'b1;
            dirty_r[way_r][0][set_r] <= 1'b0;
            dirty_r[way_r][1][set_r] <= 1'b0;
            CORE_DONE_O <= 1'b1;
            st_r <= ST_IDLE;
          end
        end
        ST_OPPUSH: begin
          if (!WB_VALID_O | wb_fire) begin
            if (dirty_r[way_r][cnt_r[2]][set_r]) begin
              WB_VALID_O <= 1'b1; WB_BUFFERED_O <= 1'b1;
              WB_ADDR_O <= {tag_r[way_r][set_r], set_r, cnt_r, 2'b00};
              WB_DATA_O <= data_r[way_r][set_r][cnt_r];
            end
            cnt_r <= cnt_r + 3'h1;
            if (cnt_r == 3'(WORDS-1)) begin
              dirty_r[way_r][0][set_r] <= 1'b0; dirty_r[way_r][1][set_r] <= 1'b0;
              if (opinv_r) valid_r[way_r][set_r] <= 1'b0;
              st_r <= ST_IDLE;
            end
          end
        end
        ST_EXT: begin
          // A single read ends on its word; a buffered store ends on the push.
          if (EXT_REQ_O & EXT_VALID_I) begin
            EXT_REQ_O    <= 1'b0;
            CORE_RDATA_O <= EXT_DATA_I;
            CORE_DONE_O  <= 1'b1;
            st_r         <= ST_IDLE;
          end else if (!EXT_REQ_O & wb_fire) begin
            CORE_DONE_O <= 1'b1;
            st_r        <= ST_IDLE;
          end
        end
        default: st_r <= ST_IDLE;
      endcase
    end
  end

  // Checks guarding the cache behaviour.
  property p_dis_nohit; @(posedge CLK_SYS_I) disable iff (!ARST_N_I) !enabled |-> !hit; endproperty
  a_dis_nohit: assert property (p_dis_nohit) else $error("Hit while cache disabled.");
  property p_wt_push; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    idle_go & CORE_WR_I & hit & cach & !BUFFERABLE_ATTR_I |=> WB_VALID_O; endproperty
  a_wt_push: assert property (p_wt_push) else $error("Write-through hit not forwarded.");
  property p_wb_nopush; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    idle_go & CORE_WR_I & hit & cach & BUFFERABLE_ATTR_I |=> CORE_DONE_O & !WB_VALID_O; endproperty
  a_wb_nopush: assert property (p_wb_nopush) else $error("Write-back hit reached memory.");
  property p_miss_st; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    idle_go & CORE_WR_I & !hit |=> WB_VALID_O & st_r == ST_EXT; endproperty
  a_miss_st: assert property (p_miss_st) else $error("Store miss not buffered.");
  property p_nc_load; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    idle_go & !CORE_WR_I & !cach |=> EXT_REQ_O & !EXT_FILL_O; endproperty
  a_nc_load: assert property (p_nc_load) else $error("Noncachable load filled.");
  property p_victim; @(posedge CLK_SYS_I) disable iff (!ARST_N_I) !lock_r[LOAD_BIT] |-> victim >= lseg; endproperty
  a_victim: assert property (p_victim) else $error("Locked segment chosen.");
  property p_ldmode; @(posedge CLK_SYS_I) disable iff (!ARST_N_I) lock_r[LOAD_BIT] |-> victim == lseg; endproperty
  a_ldmode: assert property (p_ldmode) else $error("Load mode segment ignored.");
  property p_dc_all; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    st_r == ST_IDLE & op_pend_r & opcode_r == OP_DC_ALL |=> valid_r[0] == '0 & valid_r[3] == '0; endproperty
  a_dc_all: assert property (p_dc_all) else $error("Whole flush left lines.");
  // A fill always asks for a whole line from word zero.
  property p_fill_line; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    st_r == ST_FILL |-> EXT_REQ_O & EXT_FILL_O & (EXT_ADDR_O[IDX_LSB-1:0] == '0); endproperty
  a_fill_line: assert property (p_fill_line) else $error("Fill not a whole line.");
  // No core access completes in the cycle after an idle cycle with maintenance or a buffer push outstanding.
  property p_op_first; @(posedge CLK_SYS_I) disable iff (!ARST_N_I)
    st_r == ST_IDLE & (op_pend_r | WB_VALID_O) |=> !CORE_DONE_O; endproperty
  a_op_first: assert property (p_op_first) else $error("Core served before maintenance.");
endmodule : dcache_ctrl
`default_nettype wire

// ===== verification/data_cache_controller_tb_top.sv
// Self-checking bench for the data cache controller.
`timescale 1ns/10ps
`default_nettype none
module data_cache_controller_tb_top;
  import dcache_pkg::*;
  localparam logic [31:0] A = 32'h0000_1040;  // Cachable test line.
  localparam logic [31:0] V = 32'h1234_5678;  // Value stored into it.
  logic clk, arst_n, awvalid, wvalid, bready, arvalid, rready, awready, wready, bvalid, arready, rvalid;
  logic creq, cwr, ccach, cbuf, cdone, split, ext_req, ext_fill, ext_valid, wb_valid, wb_ready, wb_buf;
  logic [7:0]  awaddr, araddr, inval, inval_seen;
  logic [1:0]  bresp, rresp, resp_q;
  logic [31:0] wdata, rdata, rdata_q, caddr, cwdata, crdata, cdata_q, ext_addr, ext_data, wb_addr, wb_data;
  logic        clean_seen, clast;
  int          fail_count, compares, cycles, ext_cnt, wb_cnt, e0, w0;
  dcache_ctrl dut (.CLK_SYS_I(clk), .ARST_N_I(arst_n), .AWADDR_I(awaddr), .AWVALID_I(awvalid),
    .AWREADY_O(awready), .WDATA_I(wdata), .WSTRB_I(4'hF), .WVALID_I(wvalid), .WREADY_O(wready),
    .BRESP_O(bresp), .BVALID_O(bvalid), .BREADY_I(bready), .ARADDR_I(araddr), .ARVALID_I(arvalid),
    .ARREADY_O(arready), .RDATA_O(rdata), .RRESP_O(rresp), .RVALID_O(rvalid), .RREADY_I(rready),
    .CORE_REQ_I(creq), .CORE_WR_I(cwr), .CORE_ADDR_I(caddr), .CORE_WDATA_I(cwdata),
    .CACHABLE_ATTR_I(ccach), .BUFFERABLE_ATTR_I(cbuf), .CORE_LAST_I(clast), .CORE_DONE_O(cdone),
    .CORE_RDATA_O(crdata), .CORE_SPLIT_O(split), .WB_VALID_O(wb_valid), .WB_ADDR_O(wb_addr),
    .WB_DATA_O(wb_data), .WB_BUFFERED_O(wb_buf), .WB_READY_I(wb_ready), .EXT_REQ_O(ext_req),
    .EXT_ADDR_O(ext_addr), .EXT_FILL_O(ext_fill), .EXT_VALID_I(ext_valid), .EXT_DATA_I(ext_data),
    .ICACHE_INVAL_O(inval));
  far_side_model far (.clk_i(clk), .arst_n_i(arst_n), .ext_req_i(ext_req), .ext_addr_i(ext_addr),
    .ext_fill_i(ext_fill), .ext_valid_o(ext_valid), .ext_data_o(ext_data), .wb_ready_o(wb_ready));
  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // Memory contents as the far side presents them.
  function automatic logic [31:0] mem(input logic [31:0] a);
    return {a[31:2], 2'b00} ^ 32'h5A5A_0000;
  endfunction
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  // Address and data go out together; each is dropped once taken.
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
    do begin
      @(posedge clk);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (!bvalid);
    bready <= 1'b0;
    resp_q = bresp;
  endtask
  task automatic axi_rd(input logic [7:0] a);
    @(posedge clk);
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    do begin
      @(posedge clk);
      if (arready) arvalid <= 1'b0;
    end while (!rvalid);
    rready <= 1'b0;
    rdata_q = rdata;
    resp_q = rresp;
  endtask
  // The request is held until the done pulse; counters are snapped first.
  task automatic core(input logic w, input logic [31:0] a, input logic [31:0] d, input logic c, input logic b);
    e0 = ext_cnt;
    w0 = wb_cnt;
    @(posedge clk);
    creq <= 1'b1; cwr <= w; caddr <= a; cwdata <= d; ccach <= c; cbuf <= b;
    do @(posedge clk); while (!cdone);
    creq <= 1'b0;
    cdata_q = crdata;
  endtask
  task automatic cache_op(input logic [3:0] op, input logic [31:0] operand);
    w0 = wb_cnt;
    axi_wr(A_CACHEOP, operand);
    axi_wr(A_OPCODE, {28'h0, op});
    repeat (40) begin
      axi_rd(A_STATUS);
      if (rdata_q[5] === 1'b0) break;
    end
  endtask
  // Traffic counters and the hang limit.
  always @(posedge clk) begin
    cycles++;
    if (ext_valid) ext_cnt++;
    if (wb_valid && wb_ready) begin
      wb_cnt++;
      if (wb_addr === A && wb_data === V) clean_seen = 1'b1;
    end
    if (inval != 8'h00) inval_seen = inval;
    if (cycles == 20000) begin
      fail_count++;
      print_verdict();
    end
  end
  initial begin
    {awvalid, wvalid, bready, arvalid, rready, creq, cwr, ccach, cbuf, clean_seen} = '0;
    awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; caddr = 32'h0; cwdata = 32'h0; inval_seen = 8'h00;
    clast = 1'b1;
    arst_n = 1'b0;
    repeat (12) @(posedge clk);
    arst_n <= 1'b1;
    repeat (2) @(posedge clk);
    axi_rd(A_CTRL); check(rdata_q, 32'h0);
    axi_rd(8'h40); check({30'h0, resp_q}, {30'h0, RESP_SLVERR});
    axi_wr(A_CTRL, 32'h4); axi_rd(A_STATUS); check({31'h0, rdata_q[4]}, 32'h0);
    axi_wr(A_CTRL, 32'h5); axi_rd(A_STATUS); check({31'h0, rdata_q[4]}, 32'h1);
    core(1'b0, A, 32'h0, 1'b1, 1'b1); check(cdata_q, mem(A));
    check(32'(ext_cnt - e0), 32'h8);
    core(1'b0, A + 32'h4, 32'h0, 1'b1, 1'b1); check(cdata_q, mem(A + 32'h4));
    check(32'(ext_cnt - e0), 32'h0);
    core(1'b1, A, V, 1'b1, 1'b1); check(32'(wb_cnt - w0), 32'h0);
    core(1'b1, A + 32'h8, ~V, 1'b1, 1'b0); check(32'(wb_cnt - w0), 32'h1);
    core(1'b0, A + 32'h8, 32'h0, 1'b1, 1'b1); check(cdata_q, ~V);
    core(1'b1, 32'h0000_8000, V, 1'b1, 1'b1); check(32'(wb_cnt - w0), 32'h1);
    check(32'(ext_cnt - e0), 32'h0);
    core(1'b0, 32'h0001_0000, 32'h0, 1'b0, 1'b0); check(cdata_q, mem(32'h0001_0000));
    core(1'b0, 32'h0001_0000, 32'h0, 1'b0, 1'b0); check(32'(ext_cnt - e0), 32'h1);
    cache_op(OP_CLN_ADR, A); check({31'h0, clean_seen}, 32'h1);
    core(1'b0, A, 32'h0, 1'b1, 1'b1); check(cdata_q, V);
    cache_op(OP_DC_LINE, A); check(32'(wb_cnt - w0), 32'h0);
    core(1'b0, A, 32'h0, 1'b1, 1'b1); check(cdata_q, mem(A));
    cache_op(OP_IC_ALL, 32'h0); check({24'h0, inval_seen}, 32'hFF);
    axi_rd(A_ICLINE); check(rdata_q, 32'h0);
    // Lockdown: the target line is not cached yet, as the locking software must ensure.
    axi_wr(A_LOCK, 32'h8000_0000); core(1'b0, 32'h0000_2000, 32'h0, 1'b1, 1'b1); check(cdata_q, mem(32'h0000_2000));
    axi_wr(A_LOCK, 32'h1); axi_rd(A_LOCK); check(rdata_q, 32'h1);
    core(1'b0, 32'h0000_2000, 32'h0, 1'b1, 1'b1); check(32'(ext_cnt - e0), 32'h0);
    clast <= 1'b0; core(1'b0, 32'h0000_0FFC, 32'h0, 1'b0, 1'b0); check({31'h0, split}, 32'h1);
    clast <= 1'b1;
    axi_wr(A_CTRL, 32'h1);
    core(1'b0, A, 32'h0, 1'b1, 1'b1); check(32'(ext_cnt - e0), 32'h1);
    print_verdict();
  end
endmodule // data_cache_controller_tb_top
`default_nettype wire

// ===== verification/far_side_model.sv
// External memory and write buffer model facing the cache controller.
`timescale 1ns/10ps
`default_nettype none
module far_side_model (
  input  wire logic        clk_i,
  input  wire logic        arst_n_i,
  input  wire logic        ext_req_i,
  input  wire logic [31:0] ext_addr_i,
  input  wire logic        ext_fill_i,
  output logic             ext_valid_o,
  output logic [31:0]      ext_data_o,
  output logic             wb_ready_o
);
  logic [3:0]  cnt_r;    // Words handed out in this burst.
  logic [1:0]  stall_r;  // Buffer refuses one cycle in four.
  logic [31:0] word_a;   // Address of the next word.
  // A fill runs from word 0 of the line; a single access returns its own word.
  assign word_a = ext_fill_i ? {ext_addr_i[31:5], cnt_r[2:0], 2'b00} : ext_addr_i;
  // One word every other cycle, so the controller sees a slow memory.
  always_ff @(posedge clk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      cnt_r       <= 4'h0;
      stall_r     <= 2'h0;
      ext_valid_o <= 1'b0;
      ext_data_o  <= 32'h0;
      wb_ready_o  <= 1'b0;
    end else begin
      stall_r     <= stall_r + 2'h1;
      wb_ready_o  <= (stall_r != 2'h3);
      ext_valid_o <= 1'b0;
      ext_data_o  <= ~ext_data_o;  // Off-burst data is inverted each cycle, so the last word comes back every second cycle.
      if (!ext_req_i) begin
        cnt_r <= 4'h0;
      end else if (!ext_valid_o && cnt_r < (ext_fill_i ? 4'h8 : 4'h1)) begin
        ext_valid_o <= 1'b1;
        ext_data_o  <= {word_a[31:2], 2'b00} ^ 32'h5A5A_0000;
        cnt_r       <= cnt_r + 4'h1;
      end
    end
  end
endmodule // far_side_model
`default_nettype wire
